// ===== rtl/uart_chan_pkg.sv
// Constants, field layouts and carrier types of the UART channel
package uart_chan_pkg;

   localparam int ADDR_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_DATA = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_BIT_RATE_DIVIDER = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_INT_EN = 8'h0c;
   localparam logic [ADDR_W-1:0] ADDR_INT_STAT = 8'h10;
   localparam logic [ADDR_W-1:0] ADDR_LINE_STAT = 8'h14;

   localparam logic [1:0] FUNC_UART = 2'h0;
   localparam logic [1:0] FUNC_LIN = 2'h1;
   localparam logic [1:0] FUNC_IRDA = 2'h2;
   localparam logic [1:0] FUNC_RS485 = 2'h3;

   localparam int IRQ_COUNT = 7;
   localparam int IRQ_TX_EMPTY = 0;
   localparam int IRQ_RX_THRESHOLD = 1;
   localparam int IRQ_LINE_STATUS = 2;
   localparam int IRQ_RX_TIMEOUT = 3;
   localparam int IRQ_MODEM_WAKE = 4;
   localparam int IRQ_BUF_ERR = 5;
   localparam int IRQ_LIN = 6;

   localparam int FIFO_DEPTH_CHAN0 = 64;
   localparam int FIFO_DEPTH_OTHER = 16;
   localparam int FIFO_DEPTH_MAX = 64;
   localparam int DATA_BITS = 8;
   localparam int CNT_W = 21;
   localparam logic [4:0] OVERSAMPLE = 5'h10;
   localparam logic [16:0] BRD_OFFSET = 17'h00002;
   localparam int DIV_X_MIN = 8;
   localparam int BRD_MIN_UNITY = 3;
   localparam int IRDA_PULSE_MUL = 3;
   localparam int IRDA_DEN_SHIFT = 4;
   localparam int IRDA_TURNAROUND_MS = 10;

   typedef struct packed {
      logic [3:0] pad_hi;
      logic [7:0] pad_mid;
      logic [7:0] timeout;
      logic [5:0] rx_trigger;
      logic [1:0] pad_lo;
      logic rts_level;
      logic auto_flow;
      logic parity_even;
      logic parity_en;
      logic [1:0] function_select;
   } ctrl_t;

   typedef struct packed {
      logic [1:0] pad_hi;
      logic div_x_en;
      logic div_x_one;
      logic [3:0] divider_x;
      logic [7:0] pad_lo;
      logic [15:0] bit_rate_divisor;
   } baud_t;

   typedef struct packed {
      logic [4:0] pad_hi;
      logic cts;
      logic rx_busy;
      logic tx_busy;
      logic [3:0] err;
      logic tx_full;
      logic tx_empty;
      logic rx_full;
      logic rx_empty;
      logic pad_mid;
      logic [6:0] tx_count;
      logic pad_lo;
      logic [6:0] rx_count;
   } line_stat_t;

   localparam int ERR_PARITY = 0;
   localparam int ERR_FRAME = 1;
   localparam int ERR_BREAK = 2;
   localparam int ERR_BUF = 3;
   localparam logic [31:0] CTRL_MASK = 32'h00fffc3f;
   localparam logic [31:0] BAUD_MASK = 32'h3f00ffff;
   localparam logic [31:0] CTRL_RESET = 32'h00000000;
   localparam logic [31:0] BAUD_RESET = 32'h00000000;

endpackage : uart_chan_pkg

// ===== rtl/uart_channel.sv
// One UART channel with APB registers, baud generator, LIN and IrDA modes, and RS-485 mode on channels 0 and 1
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
module uart_channel #(
   parameter int CHAN = 0,
   parameter int FIFO_DEPTH = (CHAN == 0) ? uart_chan_pkg::FIFO_DEPTH_CHAN0
                                          : uart_chan_pkg::FIFO_DEPTH_OTHER
) (
   // APB slave
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [uart_chan_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Serial line
   input wire logic rxd,
   output logic txd,
   input wire logic cts_n,
   output logic chan_request_to_send_n,
   // Interrupt line
   input wire logic peer_irq,
   output logic irq
);
   import uart_chan_pkg::*;

   localparam int CW = $clog2(FIFO_DEPTH + 1);
   localparam bit HAS_FLOW = (CHAN < 2);
   localparam bit MERGE_PEER = (CHAN == 0);

   if (CHAN < 0 || CHAN > 2) begin : g_bad_chan
      $error("uart_channel: CHAN must be 0, 1 or 2");
   end
   if (FIFO_DEPTH < 2 || FIFO_DEPTH > FIFO_DEPTH_MAX) begin : g_bad_depth
      $error("uart_channel: FIFO_DEPTH out of range");
   end

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PARITY, TX_STOP} tx_state_t;
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Registers and APB decode

   ctrl_t ctrl;
   baud_t baud;
   logic [IRQ_COUNT-1:0] int_en;
   logic [IRQ_COUNT-1:0] int_stat;
   logic [3:0] err;

   wire access = psel && penable;
   wire done = access && pready;
   wire wr_done = done && pwrite;
   wire rd_done = done && !pwrite;
   wire sel_data = (paddr == ADDR_DATA);
   wire sel_ctrl = (paddr == ADDR_CTRL);
   wire sel_baud = (paddr == ADDR_BIT_RATE_DIVIDER);
   wire sel_int_en = (paddr == ADDR_INT_EN);
   wire sel_int_stat = (paddr == ADDR_INT_STAT);
   wire sel_line = (paddr == ADDR_LINE_STAT);
   wire mapped = sel_data || sel_ctrl || sel_baud || sel_int_en || sel_int_stat || sel_line;

   wire lin_mode = (ctrl.function_select == FUNC_LIN);
   wire irda_mode = (ctrl.function_select == FUNC_IRDA);
   wire rs485_mode = (ctrl.function_select == FUNC_RS485);
   // UART and RS-485 share the plain framing path
   wire par_en = ctrl.parity_en && !lin_mode;

   ////////////////////////////////////////////////////////////////////////////
   // FIFOs

   logic tx_push;
   logic tx_pop;
   logic [7:0] tx_dout;
   logic [CW-1:0] tx_count;
   logic tx_full;
   logic tx_empty;
   logic rx_push;
   logic [7:0] rx_din;
   logic [7:0] rx_dout;
   logic [CW-1:0] rx_count;
   logic rx_full;
   logic rx_empty;

   assign tx_push = wr_done && sel_data;
   wire rx_pop = rd_done && sel_data;

   // Depth follows the channel number
   uart_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
      .pclk(pclk), .presetn(presetn), .push(tx_push), .din(pwdata[DATA_BITS-1:0]),
      .pop(tx_pop), .dout(tx_dout), .count(tx_count), .full(tx_full), .empty(tx_empty)
   );
   uart_fifo #(.WIDTH(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
      .pclk(pclk), .presetn(presetn), .push(rx_push), .din(rx_din),
      .pop(rx_pop), .dout(rx_dout), .count(rx_count), .full(rx_full), .empty(rx_empty)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Baud generator: clocks per bit is M * (divisor + 2)

   wire [4:0] mult = !baud.div_x_en ? OVERSAMPLE
                   : baud.div_x_one ? 5'h01
                   : {1'b0, baud.divider_x} + 5'h01;
   wire [16:0] brd_plus = {1'b0, baud.bit_rate_divisor} + BRD_OFFSET;
   wire [CNT_W-1:0] bit_clocks = CNT_W'({16'h0000, mult} * {4'h0, brd_plus});
   wire [CNT_W-1:0] bit_last = bit_clocks - 1'b1;
   wire [CNT_W-1:0] half_bit = bit_clocks >> 1;
   wire [CNT_W+1:0] triple = {bit_clocks, 1'b0} + {2'b00, bit_clocks};
   wire [CNT_W-1:0] irda_raw = CNT_W'(triple >> IRDA_DEN_SHIFT);
   wire [CNT_W-1:0] irda_len = (irda_raw == '0) ? CNT_W'(1) : irda_raw;
   wire [CNT_W-1:0] stretch_len = bit_clocks - (bit_clocks >> 2);

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers

   logic rx_meta;
   logic rx_sync;
   logic rx_sync_d;
   logic cts_meta;
   logic cts_sync;
   logic cts_sync_d;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {rx_meta, rx_sync, rx_sync_d} <= 3'h7;
         {cts_meta, cts_sync, cts_sync_d} <= 3'h7;
      end else begin
         {rx_meta, rx_sync, rx_sync_d} <= {rxd, rx_meta, rx_sync};
         {cts_meta, cts_sync, cts_sync_d} <= {cts_n, cts_meta, cts_sync};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter

   tx_state_t tx_state;
   tx_state_t next_tx_state;
   logic [CNT_W-1:0] tx_cnt;
   logic [2:0] tx_bit;
   logic [7:0] tx_shift;
   logic tx_par;
   logic tx_level;

   wire tx_busy = (tx_state != TX_IDLE);
   wire tx_bit_end = (tx_cnt == bit_last);
   wire cts_ok = !(HAS_FLOW && ctrl.auto_flow && cts_sync);
   assign tx_pop = (tx_state == TX_IDLE) && !tx_empty && cts_ok;

   always_comb begin
      next_tx_state = tx_state;
      tx_level = 1'b1;
      case (tx_state)
         TX_IDLE: begin
            if (tx_pop) next_tx_state = TX_START;
         end
         TX_START: begin
            tx_level = 1'b0;
            if (tx_bit_end) next_tx_state = TX_DATA;
         end
         TX_DATA: begin
            tx_level = tx_shift[0];
            if (tx_bit_end && tx_bit == 3'h7) next_tx_state = par_en ? TX_PARITY : TX_STOP;
         end
         TX_PARITY: begin
            tx_level = tx_par;
            if (tx_bit_end) next_tx_state = TX_STOP;
         end
         TX_STOP: begin
            if (tx_bit_end) next_tx_state = TX_IDLE;
         end
         default: next_tx_state = TX_IDLE;
      endcase
   end

   // IrDA sends a short high pulse for each zero bit, idling low
   wire next_txd = irda_mode ? (tx_busy && !tx_level && tx_cnt < irda_len) : tx_level;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= TX_IDLE;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_shift <= '0;
         tx_par <= 1'b0;
         txd <= 1'b1;
      end else begin
         tx_state <= next_tx_state;
         txd <= next_txd;
         tx_cnt <= (!tx_busy || tx_bit_end) ? '0 : tx_cnt + 1'b1;
         if (tx_pop) begin
            tx_shift <= tx_dout;
            tx_par <= ctrl.parity_even ? ^tx_dout : ~^tx_dout;
            tx_bit <= '0;
         end else if (tx_state == TX_DATA && tx_bit_end) begin
            tx_shift <= {1'b0, tx_shift[7:1]};
            tx_bit <= tx_bit + 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver

   rx_state_t rx_state;
   rx_state_t next_rx_state;
   logic [CNT_W-1:0] rx_cnt;
   logic [CNT_W-1:0] stretch;
   logic [2:0] rx_bit;
   logic [7:0] rx_shift;
   logic rx_par;
   logic rx_prev;

   // Receiver is blind while the IrDA encoder sends
   wire rx_line = irda_mode ? (tx_busy || stretch == '0) : rx_sync;
   wire rx_busy = (rx_state != RX_IDLE);
   wire rx_hit = (rx_state == RX_START) ? (rx_cnt == half_bit) : (rx_cnt == bit_last);
   wire stop_hit = (rx_state == RX_STOP) && rx_hit;
   wire par_exp = ctrl.parity_even ? ^rx_shift : ~^rx_shift;
   wire got_parity_err = stop_hit && par_en && (rx_par != par_exp);
   wire got_frame_err = stop_hit && !rx_line;
   wire got_break = got_frame_err && (rx_shift == '0) && !(par_en && rx_par);
   assign rx_push = stop_hit;
   assign rx_din = rx_shift;

   always_comb begin
      next_rx_state = rx_state;
      case (rx_state)
         RX_IDLE: begin
            if (rx_prev && !rx_line) next_rx_state = RX_START;
         end
         RX_START: begin
            if (rx_hit) next_rx_state = rx_line ? RX_IDLE : RX_DATA;
         end
         RX_DATA: begin
            if (rx_hit && rx_bit == 3'h7) next_rx_state = par_en ? RX_PARITY : RX_STOP;
         end
         RX_PARITY: begin
            if (rx_hit) next_rx_state = RX_STOP;
         end
         RX_STOP: begin
            if (rx_hit) next_rx_state = RX_IDLE;
         end
         default: next_rx_state = RX_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_shift <= '0;
         rx_par <= 1'b0;
         rx_prev <= 1'b1;
      end else begin
         rx_state <= next_rx_state;
         rx_prev <= rx_line;
         rx_cnt <= (!rx_busy || rx_hit) ? '0 : rx_cnt + 1'b1;
         if (rx_state == RX_START) rx_bit <= '0;
         if (rx_state == RX_DATA && rx_hit) begin
            rx_shift <= {rx_line, rx_shift[7:1]};
            rx_bit <= rx_bit + 1'b1;
         end
         if (rx_state == RX_PARITY && rx_hit) rx_par <= rx_line;
      end
   end

   // Stretch each IrDA receive pulse so the mid-bit sample sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) stretch <= '0;
      else if (rx_sync && !rx_sync_d) stretch <= stretch_len;
      else if (stretch != '0) stretch <= stretch - 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receive timeout, counted in bit times

   logic [CNT_W-1:0] tick_cnt;
   logic [7:0] idle_bits;
   logic timeout_fired;

   wire bit_tick = (tick_cnt == bit_last);
   wire idle_reset = rx_empty || rx_busy || rx_push || rx_pop;
   wire timeout_hit = !idle_reset && !timeout_fired && ctrl.timeout != '0
                      && idle_bits == ctrl.timeout;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick_cnt <= '0;
         idle_bits <= '0;
         timeout_fired <= 1'b0;
      end else begin
         tick_cnt <= bit_tick ? '0 : tick_cnt + 1'b1;
         if (idle_reset) begin
            idle_bits <= '0;
            timeout_fired <= 1'b0;
         end else begin
            if (bit_tick && idle_bits != ctrl.timeout) idle_bits <= idle_bits + 1'b1;
            if (timeout_hit) timeout_fired <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt and error status

   logic [IRQ_COUNT-1:0] irq_set;
   logic [3:0] err_set;
   wire rx_over = rx_push && rx_full;
   wire tx_over = tx_push && tx_full;
   wire rx_at_trigger = !rx_empty && ({{(8 - CW){1'b0}}, rx_count} >= {2'h0, ctrl.rx_trigger});

   always_comb begin
      irq_set = '0;
      irq_set[IRQ_TX_EMPTY] = tx_empty;
      irq_set[IRQ_RX_THRESHOLD] = rx_at_trigger;
      irq_set[IRQ_LINE_STATUS] = got_parity_err || got_frame_err || got_break;
      irq_set[IRQ_RX_TIMEOUT] = timeout_hit;
      irq_set[IRQ_MODEM_WAKE] = HAS_FLOW && (cts_sync != cts_sync_d);
      irq_set[IRQ_BUF_ERR] = rx_over || tx_over;
      irq_set[IRQ_LIN] = lin_mode && got_break;
      err_set = '0;
      err_set[ERR_PARITY] = got_parity_err;
      err_set[ERR_FRAME] = got_frame_err;
      err_set[ERR_BREAK] = got_break;
      err_set[ERR_BUF] = rx_over || tx_over;
   end

   // Write one to clear; a new event in the same cycle wins
   wire [IRQ_COUNT-1:0] irq_clr = (wr_done && sel_int_stat) ? pwdata[IRQ_COUNT-1:0] : '0;
   wire line_stat_t line_wr = line_stat_t'(pwdata);
   wire [3:0] err_clr = (wr_done && sel_line) ? line_wr.err : '0;
   wire own_irq = |(int_stat & int_en);
   wire next_irq = own_irq || (MERGE_PEER && peer_irq);

   ////////////////////////////////////////////////////////////////////////////
   // Register file and read mux

   line_stat_t line_stat;
   always_comb begin
      line_stat = '0;
      line_stat.rx_count = 7'(rx_count);
      line_stat.tx_count = 7'(tx_count);
      line_stat.rx_empty = rx_empty;
      line_stat.rx_full = rx_full;
      line_stat.tx_empty = tx_empty;
      line_stat.tx_full = tx_full;
      line_stat.err = err;
      line_stat.tx_busy = tx_busy;
      line_stat.rx_busy = rx_busy;
      line_stat.cts = HAS_FLOW && !cts_sync;
   end

   wire [31:0] rdata = sel_data ? {24'h000000, rx_empty ? 8'h00 : rx_dout}
                     : sel_ctrl ? 32'(ctrl)
                     : sel_baud ? 32'(baud)
                     : sel_int_en ? {25'h0000000, int_en}
                     : sel_int_stat ? {25'h0000000, int_stat}
                     : sel_line ? 32'(line_stat)
                     : 32'h00000000;

   // Request-to-send: direction enable, auto flow, or software level
   wire next_rts_n = !HAS_FLOW ? 1'b1
                   : rs485_mode ? !tx_busy
                   : ctrl.auto_flow ? rx_at_trigger
                   : !ctrl.rts_level;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= ctrl_t'(CTRL_RESET);
         baud <= baud_t'(BAUD_RESET);
         int_en <= '0;
         int_stat <= '0;
         err <= '0;
         irq <= 1'b0;
         chan_request_to_send_n <= 1'b1;
      end else begin
         if (wr_done && sel_ctrl) ctrl <= ctrl_t'(pwdata & CTRL_MASK);
         if (wr_done && sel_baud) baud <= baud_t'(pwdata & BAUD_MASK);
         if (wr_done && sel_int_en) int_en <= pwdata[IRQ_COUNT-1:0];
         int_stat <= (int_stat & ~irq_clr) | irq_set;
         err <= (err & ~err_clr) | err_set;
         irq <= next_irq;
         chan_request_to_send_n <= next_rts_n;
      end
   end

   // One wait state: pready rises in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= '0;
      end else begin
         pready <= access && !pready;
         pslverr <= access && !pready && !mapped;
         if (access && !pready && !pwrite) prdata <= rdata;
      end
   end
endmodule : uart_channel

// ===== rtl/uart_fifo.sv
// Byte FIFO with occupancy count
`timescale 1ns/1ps
module uart_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16,
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1,
   localparam int CW = $clog2(DEPTH + 1)
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Write side
   input wire logic push,
   input wire logic [WIDTH-1:0] din,
   // Read side
   input wire logic pop,
   output logic [WIDTH-1:0] dout,
   // Occupancy
   output logic [CW-1:0] count,
   output logic full,
   output logic empty
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   wire do_push = push && !full;
   wire do_pop = pop && !empty;
   wire [AW-1:0] last = AW'(DEPTH - 1);

   assign full = (count == CW'(DEPTH));
   assign empty = (count == '0);
   assign dout = mem[rd_ptr];

   always_ff @(posedge pclk) begin
      if (do_push) mem[wr_ptr] <= din;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_push) wr_ptr <= (wr_ptr == last) ? '0 : wr_ptr + 1'b1;
         if (do_pop) rd_ptr <= (rd_ptr == last) ? '0 : rd_ptr + 1'b1;
         if (do_push && !do_pop) count <= count + 1'b1;
         else if (do_pop && !do_push) count <= count - 1'b1;
      end
   end
endmodule : uart_fifo

// ===== tb/multi_function_uart_channel_tb.sv
// Self-checking bench for one UART channel
`timescale 1ns/1ps
module multi_function_uart_channel_tb;
   import uart_chan_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic rxd, txd, cts_n, rts_n, peer_irq, irq, e;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [9:0] f;
   int fail_count = 0;
   int comparisons = 0;
   int len;
   logic [31:0] baud [3] = '{32'h0000_0000, 32'h2800_0000, 32'h3000_0003};
   int clks [3] = '{32, 18, 5};
   uart_channel #(.CHAN(0)) uart_channel_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rxd(rxd), .txd(txd), .cts_n(cts_n), .chan_request_to_send_n(rts_n),
      .peer_irq(peer_irq), .irq(irq));
   uart_line_peer uart_line_peer_inst (.pclk(pclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
   ////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m,
                     input string what);
      apb(1'b0, a, '0, r, e);
      chk(r & m, exp, what);
   endtask : rd
   task automatic final_report;
      $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   ////////////////////////////////////////
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   initial begin
      repeat (20000) @(posedge pclk);
      fail_count++;
      final_report();
   end
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, peer_irq, paddr, pwdata} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(ADDR_CTRL, CTRL_RESET, '1, "ctrl reset");
      rd(ADDR_BIT_RATE_DIVIDER, BAUD_RESET, '1, "divider reset");
      apb(1'b0, 8'h1c, '0, r, e);
      chk(32'(e), 32'h1, "unmapped");
      chk(r, 32'h0, "unmapped data");
      for (int i = 0; i < 3; i++) begin
         wr(ADDR_BIT_RATE_DIVIDER, baud[i]);
         uart_line_peer_inst.bit_clks = clks[i];
         wr(ADDR_DATA, 32'h0000_00a5);
         uart_line_peer_inst.recv(f, len);
         chk(32'(f), 32'h34a, "frame");
         chk(len, clks[i], "bit time");
      end
      uart_line_peer_inst.send(8'h3c, 1'b1);
      repeat (6) @(posedge pclk);
      rd(ADDR_LINE_STAT, 32'h0004_0001, 32'h00ff_ffff, "rx status");
      rd(ADDR_DATA, 32'h0000_003c, '1, "rx byte");
      uart_line_peer_inst.send(8'h00, 1'b0);
      repeat (6) @(posedge pclk);
      rd(ADDR_LINE_STAT, 32'h0064_0001, 32'h00ff_ffff, "line errors");
      wr(ADDR_INT_EN, 32'h0000_0004);
      @(posedge pclk);
      chk(32'(irq), 32'h1, "line irq");
      wr(ADDR_INT_EN, 32'h0);
      peer_irq <= 1'b1;
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h1, "shared irq");
      peer_irq <= 1'b0;
      wr(ADDR_CTRL, 32'h0000_000d);
      wr(ADDR_DATA, 32'h0);
      uart_line_peer_inst.recv(f, len);
      chk(32'(f), 32'h200, "lin frame");
      wr(ADDR_CTRL, 32'h0000_000c);
      wr(ADDR_DATA, 32'h0);
      uart_line_peer_inst.recv(f, len);
      chk(32'(f), 32'h000, "parity frame");
      repeat (8) @(posedge pclk);
      wr(ADDR_CTRL, 32'h0000_0003);
      wr(ADDR_DATA, 32'h0000_00a5);
      fork
         uart_line_peer_inst.recv(f, len);
         begin
            repeat (20) @(posedge pclk);
            chk(32'(rts_n), 32'h0, "dir enable");
         end
      join
      chk(32'(f), 32'h34a, "rs485 frame");
      repeat (8) @(posedge pclk);
      chk(32'(rts_n), 32'h1, "dir release");
      uart_line_peer_inst.flow(1'b1);
      wr(ADDR_CTRL, 32'h0000_0010);
      wr(ADDR_DATA, 32'h0000_00a5);
      repeat (8) @(posedge pclk);
      rd(ADDR_LINE_STAT, 32'h0000_0100, 32'h0500_7f00, "cts hold");
      chk(32'(rts_n), 32'h1, "flow rts");
      uart_line_peer_inst.flow(1'b0);
      uart_line_peer_inst.recv(f, len);
      chk(32'(f), 32'h34a, "cts resume");
      wr(ADDR_CTRL, 32'h0000_0002);
      wr(ADDR_DATA, 32'h0000_00a5);
      len = 0;
      repeat (60) begin
         @(posedge pclk);
         len += int'(txd === 1'b1);
      end
      chk(len, 5, "irda pulses");
      repeat (20) @(posedge pclk); // Shortened turnaround before the far end answers
      uart_line_peer_inst.send_ir(8'h3c);
      repeat (6) @(posedge pclk);
      rd(ADDR_DATA, 32'h0, '1, "break byte");
      rd(ADDR_DATA, 32'h0000_003c, '1, "irda byte");
      final_report();
   end
endmodule : multi_function_uart_channel_tb

bind uart_channel uart_chan_assertions uart_chan_assertions_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .rxd(rxd), .txd(txd), .cts_n(cts_n), .chan_request_to_send_n(chan_request_to_send_n),
   .peer_irq(peer_irq), .irq(irq));

// ===== tb/uart_chan_assertions.sv
// Port-level checks of one UART channel
`timescale 1ns/1ps
module uart_chan_assertions (
   // APB
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [uart_chan_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Line and interrupt
   input wire logic rxd,
   input wire logic txd,
   input wire logic cts_n,
   input wire logic chan_request_to_send_n,
   input wire logic peer_irq,
   input wire logic irq
);
   import uart_chan_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   ////////////////////////////////////////
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("pready held too long");
   chk_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("pready late");
   chk_ready_cause: assert property (pready |-> $past(psel && penable))
      else $error("pready without access");
   chk_err_qualified: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   chk_rdata_hold: assert property ($changed(prdata) |-> pready)
      else $error("prdata moved outside answer");
   chk_irq_peer: assert property (peer_irq |=> irq)
      else $error("shared line not merged");
   chk_irq_drop: assert property ($fell(irq) |-> !$past(peer_irq))
      else $error("irq fell under peer");
   chk_start_hold: assert property ($fell(txd) |-> !txd [*4])
      else $error("low bit too short");
   cover property (pslverr);
   cover property (irq && !peer_irq);
   cover property ($fell(txd));
endmodule : uart_chan_assertions

// ===== tb/uart_line_peer.sv
// Far-end serial device that frames and captures characters
`timescale 1ns/1ps
module uart_line_peer (
   // Line
   input wire logic pclk,
   input wire logic txd,
   output logic rxd,
   output logic cts_n
);
   int bit_clks = 5;
   initial begin
      rxd = 1'b1;
      cts_n = 1'b0;
   end
   task automatic send(input logic [7:0] b, input logic stop);
      logic [9:0] fr;
      fr = {stop, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rxd <= fr[i];
         repeat (bit_clks) @(posedge pclk);
      end
      rxd <= 1'b1;
   endtask : send
   // Pulse-coded frame: idle low, short high pulse per zero bit
   task automatic send_ir(input logic [7:0] b);
      logic [9:0] fr;
      fr = {1'b1, b, 1'b0};
      rxd <= 1'b0;
      repeat (bit_clks) @(posedge pclk);
      for (int i = 0; i < 10; i++) begin
         rxd <= !fr[i];
         @(posedge pclk);
         rxd <= 1'b0;
         repeat (bit_clks - 1) @(posedge pclk);
      end
   endtask : send_ir
   task automatic flow(input logic v);
      cts_n <= v;
   endtask : flow
   task automatic recv(output logic [9:0] fr, output int len);
      int k;
      k = 0;
      while (txd !== 1'b0 && k < 9000) begin
         @(posedge pclk);
         k++;
      end
      fr = '1;
      len = 0;
      for (k = 0; k < 10 * bit_clks; k++) begin
         if (k % bit_clks == bit_clks / 2) fr[k / bit_clks] = txd;
         if (txd === 1'b0 && len == k) len++;
         @(posedge pclk);
      end
   endtask : recv
endmodule : uart_line_peer
